// ==== rtl/sic_pkg.sv ====
// Constants and types of the indexed configuration port block
// What this block does
// - Strap enables index 015Ch, data 015Dh ports
// - Strap sets motherboard mode, no isolation needed
// - Device selector resets 00h, picks nine devices
// - Read-port, wake, card select reset to 00h
// - Fixed chip identifier readable at index 20h
// - Global configs 21h/22h reset D6h, 02h
// - Chip-select index 23h, data 24h, reset 00h
// - Per device: 30h activation, 31h range check
// - Per device: data base 60/61h, command 62/63h
// - Per device: interrupt select 70h, type 71h
// - Per device: DMA assignment at 74h/75h
// - F0h device config; F1h floppy_drive_ident, device 03
// - Eleven general-purpose pins, per-pin direction
// - GPIO port 1 at 0078h, port 2 007Ch
// - Run-time functions use fixed PC addresses
package sic_pkg;
   localparam logic [15:0] IDX_PORT = 16'h015C;
   localparam logic [15:0] DAT_PORT = 16'h015D;
   localparam logic [15:0] GPIO_BASE = 16'h0078;
   localparam logic [7:0] IX_RDPORT = 8'h00;
   localparam logic [7:0] IX_WAKE = 8'h03;
   localparam logic [7:0] IX_CSN = 8'h06;
   localparam logic [7:0] IX_LDN = 8'h07;
   localparam logic [7:0] IX_CHIPID = 8'h20;
   localparam logic [7:0] IX_GCFG_A = 8'h21;
   localparam logic [7:0] IX_GCFG_B = 8'h22;
   localparam logic [7:0] IX_CS_IDX = 8'h23;
   localparam logic [7:0] IX_CS_DAT = 8'h24;
   localparam logic [7:0] IX_ACT = 8'h30;
   localparam logic [7:0] IX_RCHK = 8'h31;
   localparam logic [7:0] IX_DBASE_HI = 8'h60;
   localparam logic [7:0] IX_DBASE_LO = 8'h61;
   localparam logic [7:0] IX_CBASE_HI = 8'h62;
   localparam logic [7:0] IX_CBASE_LO = 8'h63;
   localparam logic [7:0] IX_IRQ_SEL = 8'h70;
   localparam logic [7:0] IX_IRQ_TYPE = 8'h71;
   localparam logic [7:0] IX_DMA_A = 8'h74;
   localparam logic [7:0] IX_DMA_B = 8'h75;
   localparam logic [7:0] IX_DEV_CFG = 8'hF0;
   localparam logic [7:0] IX_FLOPPY_DRIVE_IDENT = 8'hF1;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_GCFG_A = 8'hD6;
   localparam logic [7:0] RST_GCFG_B = 8'h02;
   localparam logic [7:0] LDN_KBD = 8'h00;
   localparam logic [7:0] LDN_FDC = 8'h03;
   localparam logic [7:0] LDN_LPT = 8'h04;
   localparam logic [7:0] LDN_SER2 = 8'h05;
   localparam logic [7:0] LDN_SER1 = 8'h06;
   localparam int NDEV = 9;
   localparam logic [7:0] NDEV_B = 8'h09;
   localparam int NCS = 8;
   localparam int NGPIO = 11;
   localparam int GP1_PINS = 4;
   localparam logic [7:0] GP1_MASK = 8'h0F;
   localparam logic [7:0] GP2_MASK = 8'hFE;
   localparam logic [7:0] CHIP_ID_DEF = 8'h5A; // Arbitrary value

   // Host I/O cycle, one cycle per access
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } sic_io_req_t;

   // Read answer, one cycle after the read
   typedef struct packed {
      logic ack;
      logic [7:0] data;
   } sic_io_rsp_t;
endpackage

// ==== rtl/sic_config_port.sv ====
// Indexed configuration port, GPIO ports and run-time decode
`timescale 1ns/1ps
module sic_config_port #(
   parameter logic [7:0] P_CHIP_ID = sic_pkg::CHIP_ID_DEF
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_strap_pnp,
   input wire sic_pkg::sic_io_req_t i_io,
   output sic_pkg::sic_io_rsp_t o_io,
   input wire logic [sic_pkg::NGPIO-1:0] i_gpio_in,
   output logic [sic_pkg::NGPIO-1:0] o_gpio_out,
   output logic [sic_pkg::NGPIO-1:0] o_gpio_oe,
   output logic o_cfg_en,
   output logic [4:0] o_rt_sel
);
   import sic_pkg::*;

   typedef struct packed {
      logic strap_done;
      logic cfg_en;
      logic [7:0] index;
      logic [7:0] ldn;
      logic [7:0] rd_port;
      logic [7:0] wake;
      logic [7:0] card_select_number;
      logic [7:0] gcfg_a;
      logic [7:0] gcfg_b;
      logic [7:0] cs_idx;
      logic [NCS-1:0][7:0] cs_dat;
      logic [NDEV-1:0][7:0] act;
      logic [NDEV-1:0][7:0] rchk;
      logic [NDEV-1:0][15:0] dbase;
      logic [NDEV-1:0][15:0] cbase;
      logic [NDEV-1:0][7:0] irq_sel;
      logic [NDEV-1:0][7:0] irq_type;
      logic [NDEV-1:0][15:0] dma;
      logic [NDEV-1:0][7:0] dev_cfg;
      logic [7:0] floppy_drive_ident;
      logic [1:0][7:0] gp_data;
      logic [1:0][7:0] gp_dir;
      logic [1:0][7:0] gp_type;
      logic [1:0][7:0] gp_pull;
      logic ack;
      logic [7:0] rdata;
      logic [4:0] rt_sel;
   } sic_state_t;

   sic_state_t q, d;
   logic [1:0][7:0] gp_pin;
   logic [1:0][7:0] gp_mask;
   logic dat_hit, idx_hit, gp_hit, ld_ok;
   logic [3:0] ld;
   logic [2:0] csi;
   logic [7:0] dev_rd, gp_rd;
   logic [15:0] a;

   assign gp_mask[0] = GP1_MASK;
   assign gp_mask[1] = GP2_MASK;
   assign gp_pin[0][7:GP1_PINS] = 4'h0;
   assign gp_pin[1][0] = 1'b0;

   // Pin map: port 1 bits 3..0, port 2 bits 7..1
   for (genvar i = 0; i < NGPIO; i++) begin : g_pin
      localparam int P = (i < GP1_PINS) ? 0 : 1;
      localparam int B = (i < GP1_PINS) ? i : i - GP1_PINS + 1;
      assign gp_pin[P][B] = i_gpio_in[i];
      assign o_gpio_out[i] = q.gp_data[P][B];
      assign o_gpio_oe[i] = q.gp_dir[P][B];
   end

   assign o_io.ack = q.ack;
   assign o_io.data = q.rdata;
   assign o_cfg_en = q.cfg_en;
   assign o_rt_sel = q.rt_sel;

   // Address decode of the current host cycle
   always_comb begin
      a = i_io.addr;
      idx_hit = q.cfg_en && a == IDX_PORT;
      dat_hit = q.cfg_en && a == DAT_PORT;
      gp_hit = a[15:3] == GPIO_BASE[15:3];
      ld_ok = q.ldn < NDEV_B;
      ld = q.ldn[3:0];
      csi = q.cs_idx[2:0];
   end

   // Per-device bank read for the selected device only
   always_comb begin
      dev_rd = RST_ZERO;
      if (ld_ok) begin
         unique case (q.index)
            IX_ACT: dev_rd = q.act[ld];
            IX_RCHK: dev_rd = q.rchk[ld];
            IX_DBASE_HI: dev_rd = q.dbase[ld][15:8];
            IX_DBASE_LO: dev_rd = q.dbase[ld][7:0];
            IX_CBASE_HI: dev_rd = q.cbase[ld][15:8];
            IX_CBASE_LO: dev_rd = q.cbase[ld][7:0];
            IX_IRQ_SEL: dev_rd = q.irq_sel[ld];
            IX_IRQ_TYPE: dev_rd = q.irq_type[ld];
            IX_DMA_A: dev_rd = q.dma[ld][15:8];
            IX_DMA_B: dev_rd = q.dma[ld][7:0];
            IX_DEV_CFG: dev_rd = q.dev_cfg[ld];
            IX_FLOPPY_DRIVE_IDENT:
               dev_rd = (q.ldn == LDN_FDC) ? q.floppy_drive_ident : RST_ZERO;
            default: dev_rd = RST_ZERO;
         endcase
      end
   end

   // GPIO port read: output pins show the latch, inputs the pin
   always_comb begin
      unique case (a[1:0])
         2'h0: gp_rd = ((q.gp_data[a[2]] & q.gp_dir[a[2]])
                        | (gp_pin[a[2]] & ~q.gp_dir[a[2]]))
                       & gp_mask[a[2]];
         2'h1: gp_rd = q.gp_dir[a[2]];
         2'h2: gp_rd = q.gp_type[a[2]];
         2'h3: gp_rd = q.gp_pull[a[2]];
      endcase
   end

   // Next-state logic for every register of the block
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.rdata = RST_ZERO;
      // Strap caught once, on the first edge after reset release
      if (!q.strap_done) begin
         d.strap_done = 1'b1;
         d.cfg_en = i_strap_pnp;
      end
      // Run-time decode, gated by each device's activation bit
      d.rt_sel = 5'h00;
      if (i_io.rd || i_io.wr) begin
         d.rt_sel[0] = q.act[LDN_KBD][0]
                       && (a == 16'h0060 || a == 16'h0064);
         d.rt_sel[1] = q.act[LDN_FDC][0] && a[15:3] == 13'h007E
                       && a != 16'h03F6;
         d.rt_sel[2] = q.act[LDN_LPT][0] && a[15:3] == 13'h006F;
         d.rt_sel[3] = q.act[LDN_SER2][0] && a[15:3] == 13'h005F;
         d.rt_sel[4] = q.act[LDN_SER1][0] && a[15:3] == 13'h007F;
      end
      // Reads answer on the next cycle
      if (i_io.rd && (idx_hit || dat_hit || gp_hit)) begin
         d.ack = 1'b1;
         if (idx_hit) begin
            d.rdata = q.index;
         end else if (gp_hit) begin
            d.rdata = gp_rd;
         end else begin
            unique case (q.index)
               IX_CSN: d.rdata = q.card_select_number;
               IX_LDN: d.rdata = q.ldn;
               IX_CHIPID: d.rdata = P_CHIP_ID;
               IX_GCFG_A: d.rdata = q.gcfg_a;
               IX_GCFG_B: d.rdata = q.gcfg_b;
               IX_CS_IDX: d.rdata = q.cs_idx;
               IX_CS_DAT: d.rdata = q.cs_dat[csi];
               default: d.rdata = dev_rd;
            endcase
         end
      end
      // Index port keeps the last value written
      if (i_io.wr && idx_hit) begin
         d.index = i_io.wdata;
      end
      // GPIO writes, unused bit positions forced low
      if (i_io.wr && gp_hit) begin
         unique case (a[1:0])
            2'h0: d.gp_data[a[2]] = i_io.wdata & gp_mask[a[2]];
            2'h1: d.gp_dir[a[2]] = i_io.wdata & gp_mask[a[2]];
            2'h2: d.gp_type[a[2]] = i_io.wdata & gp_mask[a[2]];
            2'h3: d.gp_pull[a[2]] = i_io.wdata & gp_mask[a[2]];
         endcase
      end
      // Data port writes land in card and global registers, else in the selected device only
      if (i_io.wr && dat_hit) begin
         unique case (q.index)
            IX_RDPORT: d.rd_port = i_io.wdata;
            IX_WAKE: d.wake = i_io.wdata;
            IX_CSN: d.card_select_number = i_io.wdata;
            IX_LDN: d.ldn = i_io.wdata;
            IX_GCFG_A: d.gcfg_a = i_io.wdata;
            IX_GCFG_B: d.gcfg_b = i_io.wdata;
            IX_CS_IDX: d.cs_idx = i_io.wdata;
            IX_CS_DAT: d.cs_dat[csi] = i_io.wdata;
            default: begin
               if (ld_ok) begin
                  unique case (q.index)
                     IX_ACT: d.act[ld] = i_io.wdata;
                     IX_RCHK: d.rchk[ld] = i_io.wdata;
                     IX_DBASE_HI: d.dbase[ld][15:8] = i_io.wdata;
                     IX_DBASE_LO: d.dbase[ld][7:0] = i_io.wdata;
                     IX_CBASE_HI: d.cbase[ld][15:8] = i_io.wdata;
                     IX_CBASE_LO: d.cbase[ld][7:0] = i_io.wdata;
                     IX_IRQ_SEL: d.irq_sel[ld] = i_io.wdata;
                     IX_IRQ_TYPE: d.irq_type[ld] = i_io.wdata;
                     IX_DMA_A: d.dma[ld][15:8] = i_io.wdata;
                     IX_DMA_B: d.dma[ld][7:0] = i_io.wdata;
                     IX_DEV_CFG: d.dev_cfg[ld] = i_io.wdata;
                     IX_FLOPPY_DRIVE_IDENT: begin
                        if (q.ldn == LDN_FDC) begin
                           d.floppy_drive_ident = i_io.wdata;
                        end
                     end
                     default: d.act[ld] = q.act[ld];
                  endcase
               end
            end
         endcase
      end
   end

   // Single state register; reset values are constants only
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         q <= '0;
         q.gcfg_a <= RST_GCFG_A;
         q.gcfg_b <= RST_GCFG_B;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_strap_mode: assert property (
      q.strap_done && !$past(q.strap_done)
      |-> q.cfg_en == $past(i_strap_pnp))
      else $error("config enable does not follow strap");
   a_index_port: assert property (
      i_io.wr && i_io.addr == IDX_PORT && q.cfg_en
      |=> q.index == $past(i_io.wdata))
      else $error("index port write not taken");
   a_index_hold: assert property (
      !(i_io.wr && i_io.addr == IDX_PORT) |=> $stable(q.index))
      else $error("index changed without index write");
   a_card_reset: assert property (
      $past(!i_reset_n) |-> q.rd_port == RST_ZERO
      && q.wake == RST_ZERO && q.card_select_number == RST_ZERO && q.ldn == RST_ZERO)
      else $error("card registers bad after reset");
   a_global_reset: assert property (
      $past(!i_reset_n) |-> q.gcfg_a == RST_GCFG_A
      && q.gcfg_b == RST_GCFG_B)
      else $error("global config reset values wrong");
   a_cs_reset: assert property (
      $past(!i_reset_n) |-> q.cs_idx == RST_ZERO && q.cs_dat == '0)
      else $error("chip select registers not cleared");
   a_chip_id: assert property (
      i_io.rd && i_io.addr == DAT_PORT && q.cfg_en
      && q.index == IX_CHIPID |=> o_io.ack && o_io.data == P_CHIP_ID)
      else $error("chip identifier read wrong");
   a_floppy_drive_ident_sel: assert property (
      q.ldn != LDN_FDC |=> $stable(q.floppy_drive_ident))
      else $error("floppy_drive_ident changed in other device");
   a_gpio_dir: assert property (
      i_io.wr && i_io.addr == 16'h0079
      |=> o_gpio_oe[3:0] == $past(i_io.wdata[3:0]))
      else $error("port 1 direction not applied");
   a_rt_kbd: assert property (
      i_io.rd && i_io.addr == 16'h0060 && q.act[LDN_KBD][0]
      |=> o_rt_sel[0])
      else $error("keyboard run-time decode missed");

   // Selector write lands as written
   a_ldn_write: assert property (
      i_io.wr && dat_hit && q.index == IX_LDN
      |=> q.ldn == $past(i_io.wdata))
      else $error("device selector write lost");

   // Selector reads back through the data port
   a_ldn_read: assert property (
      i_io.rd && dat_hit && q.index == IX_LDN
      |=> o_io.ack && o_io.data == $past(q.ldn))
      else $error("device selector read wrong");

   // Card select number is writable
   a_csn_write: assert property (
      i_io.wr && dat_hit && q.index == IX_CSN
      |=> q.card_select_number == $past(i_io.wdata))
      else $error("card select number write lost");

   // Read-port setting is writable
   a_rdport_write: assert property (
      i_io.wr && dat_hit && q.index == IX_RDPORT
      |=> q.rd_port == $past(i_io.wdata))
      else $error("read port setting write lost");

   // Global config A is writable after reset
   a_gcfg_write: assert property (
      i_io.wr && dat_hit && q.index == IX_GCFG_A
      |=> q.gcfg_a == $past(i_io.wdata))
      else $error("global config write lost");

   // Chip-select data goes to the entry picked by the index
   a_cs_data: assert property (
      i_io.wr && dat_hit && q.index == IX_CS_DAT
      |=> q.cs_dat[$past(csi)] == $past(i_io.wdata))
      else $error("chip select entry write lost");

   // Activation byte lands in the selected bank
   a_act_write: assert property (
      i_io.wr && dat_hit && q.index == IX_ACT && ld_ok
      |=> q.act[$past(ld)] == $past(i_io.wdata))
      else $error("activation write lost");

   // Data base high byte lands in the selected bank
   a_dbase_write: assert property (
      i_io.wr && dat_hit && q.index == IX_DBASE_HI && ld_ok
      |=> q.dbase[$past(ld)][15:8] == $past(i_io.wdata))
      else $error("data base write lost");

   // Interrupt select lands in the selected bank
   a_irq_write: assert property (
      i_io.wr && dat_hit && q.index == IX_IRQ_SEL && ld_ok
      |=> q.irq_sel[$past(ld)] == $past(i_io.wdata))
      else $error("interrupt select write lost");

   // DMA low byte lands in the selected bank
   a_dma_write: assert property (
      i_io.wr && dat_hit && q.index == IX_DMA_B && ld_ok
      |=> q.dma[$past(ld)][7:0] == $past(i_io.wdata))
      else $error("dma assignment write lost");

   // Out-of-range selector leaves the act, dbase and dma banks alone
   a_bank_guard: assert property (
      i_io.wr && dat_hit && !ld_ok
      |=> $stable(q.act) && $stable(q.dbase) && $stable(q.dma))
      else $error("bank changed with bad selector");

   // Floppy_drive_ident hidden outside the diskette device
   a_floppy_drive_ident_rd: assert property (
      i_io.rd && dat_hit && q.index == IX_FLOPPY_DRIVE_IDENT && q.ldn != LDN_FDC
      |=> o_io.ack && o_io.data == RST_ZERO)
      else $error("floppy_drive_ident visible in other device");

   // Both GPIO ports answer every read
   a_gpio_ack: assert property (
      i_io.rd && i_io.addr[15:3] == GPIO_BASE[15:3]
      |=> o_io.ack)
      else $error("gpio port read not answered");

   // Nothing answers outside the decoded ranges
   a_no_ack: assert property (
      !(i_io.rd && (idx_hit || dat_hit || gp_hit))
      |=> !o_io.ack && o_io.data == RST_ZERO)
      else $error("answer without decoded read");

   // Strap low keeps the config ports off until reset
   a_cfg_off: assert property (
      q.strap_done && !q.cfg_en
      |=> !q.cfg_en)
      else $error("config ports woke without strap");

   // Index port reads back the held index
   a_index_read: assert property (
      i_io.rd && idx_hit
      |=> o_io.ack && o_io.data == $past(q.index))
      else $error("index read back wrong");

   // The 3F6 hole belongs to the disk controller, not diskette
   a_rt_fdc_gap: assert property (
      (i_io.rd || i_io.wr) && i_io.addr == 16'h03F6
      |=> !o_rt_sel[1])
      else $error("diskette decode hit 3F6");

   // Unused direction bits can never drive a pin
   a_gpio_mask: assert property (
      q.gp_dir[0][7:4] == 4'h0
      && q.gp_dir[1][0] == 1'b0)
      else $error("unused gpio direction bit set");

   c_bank_wr: cover property (
      i_io.wr && dat_hit && q.index == IX_DBASE_HI && ld_ok);

   c_ldn_write: cover property (
      i_io.wr && i_io.addr == DAT_PORT && q.cfg_en && q.index == IX_LDN);
   c_chip_id: cover property (o_io.ack && q.index == IX_CHIPID);
   c_gpio_rd: cover property (i_io.rd && i_io.addr == 16'h007C);
   c_rt_ser1: cover property (o_rt_sel[4]);
endmodule // sic_config_port

// ==== dv/sic_host_model.sv ====
// Host model issuing single-cycle I/O reads and writes
`timescale 1ns/1ps
module sic_host_model (
   input wire logic i_sys_clk,
   input wire sic_pkg::sic_io_rsp_t i_io,
   output sic_pkg::sic_io_req_t o_io
);
   import sic_pkg::*;

   // Bus idle with both strobes low from time zero
   initial begin
      o_io = '0;
   end

   // One write strobe per access, launched off the falling edge
   task automatic io_wr(input logic [15:0] addr, input logic [7:0] data);
      @(negedge i_sys_clk);
      o_io.addr = addr;
      o_io.wdata = data;
      o_io.wr = 1'b1;
      @(negedge i_sys_clk);
      o_io.wr = 1'b0;
      o_io.wdata = ~data; // Released data never repeats the last byte
   endtask

   // Read strobe only; returns just after the read edge has passed
   task automatic io_strobe(input logic [15:0] addr);
      @(negedge i_sys_clk);
      o_io.addr = addr;
      o_io.rd = 1'b1;
      @(negedge i_sys_clk);
      o_io.rd = 1'b0;
   endtask

   // Read with a bounded wait for the one-cycle registered answer
   task automatic io_rd(input logic [15:0] addr, output logic [7:0] data,
                        output logic ok);
      ok = 1'b0;
      data = 8'h00;
      io_strobe(addr);
      // Answer stands one cycle from the edge after the strobe
      for (int n = 0; n < 3; n++) begin
         if (ok !== 1'b1 && i_io.ack === 1'b1) begin
            ok = 1'b1;
            data = i_io.data;
         end
         @(negedge i_sys_clk);
      end
   endtask
endmodule // sic_host_model

// ==== dv/superio_indexed_config_port_bench.sv ====
// Self-checking bench for the indexed configuration port block
`timescale 1ns/1ps
module superio_indexed_config_port_bench;
   import sic_pkg::*;
   localparam logic [7:0] TEST_ID = 8'h3C; // Arbitrary value
   localparam logic [7:0] DEV_IX [11] = '{IX_ACT, IX_RCHK, IX_DBASE_HI,
      IX_DBASE_LO, IX_CBASE_HI, IX_CBASE_LO, IX_IRQ_SEL, IX_IRQ_TYPE,
      IX_DMA_A, IX_DMA_B, IX_DEV_CFG};
   localparam logic [15:0] RT_ADDR [6] = '{16'h0060, 16'h03F0, 16'h03F6,
      16'h0378, 16'h02F8, 16'h03F8};
   localparam logic [4:0] RT_EXP [6] = '{5'h01, 5'h02, 5'h00, 5'h04,
      5'h08, 5'h10};
   logic i_sys_clk;
   logic i_reset_n;
   logic i_strap_pnp;
   sic_io_req_t io_req;
   sic_io_rsp_t io_rsp;
   logic [NGPIO-1:0] gpio_in;
   logic [NGPIO-1:0] gpio_out;
   logic [NGPIO-1:0] gpio_oe;
   logic cfg_en;
   logic [4:0] rt_sel;
   int n_mismatch = 0;
   int check_count = 0;
   logic [7:0] rd_data;
   logic rd_ok;

   sic_config_port #(.P_CHIP_ID(TEST_ID)) dut (.i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n), .i_strap_pnp(i_strap_pnp), .i_io(io_req),
      .o_io(io_rsp), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
      .o_gpio_oe(gpio_oe), .o_cfg_en(cfg_en), .o_rt_sel(rt_sel));
   sic_host_model host (.i_sys_clk(i_sys_clk), .i_io(io_rsp),
      .o_io(io_req));

   // 20 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Reset held 16 cycles; config ports usable from the 2nd edge after
   task automatic do_reset(input logic strap);
      @(negedge i_sys_clk);
      i_reset_n = 1'b0;
      i_strap_pnp = strap;
      repeat (16) @(negedge i_sys_clk);
      i_reset_n = 1'b1;
      repeat (3) @(negedge i_sys_clk);
   endtask

   // Index first, then data port
   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] data);
      host.io_wr(IDX_PORT, idx);
      host.io_wr(DAT_PORT, data);
   endtask

   task automatic cfg_chk(input string what, input logic [7:0] idx,
                          input logic [7:0] exp);
      host.io_wr(IDX_PORT, idx);
      host.io_rd(DAT_PORT, rd_data, rd_ok);
      chk({what, " ack"}, 16'h1, {15'h0, rd_ok});
      chk(what, {8'h00, exp}, {8'h00, rd_data});
   endtask

   function automatic logic [7:0] pat(input int d, input int k);
      return {d[3:0], k[3:0]} ^ 8'hC3;
   endfunction

   // Watchdog: the whole sequence needs well under 1 ms
   initial begin
      #2000000;
      n_mismatch++;
      $display("[FAIL] watchdog expected finish seen hang");
      stop_test();
   end

   // Main sequence
   initial begin
      i_reset_n = 1'b0;
      i_strap_pnp = 1'b1;
      gpio_in = '0;
      do_reset(1'b1);
      chk("cfg_en", 16'h1, {15'h0, cfg_en});
      cfg_chk("gcfg_a", IX_GCFG_A, 8'hD6);
      cfg_chk("gcfg_b", IX_GCFG_B, 8'h02);
      cfg_chk("cs_idx", IX_CS_IDX, 8'h00);
      cfg_chk("cs_dat", IX_CS_DAT, 8'h00);
      cfg_chk("dev_sel", IX_LDN, 8'h00);
      cfg_chk("card_select_number", 8'h06, 8'h00);
      cfg_chk("read_port", IX_RDPORT, 8'h00);
      cfg_chk("wake", IX_WAKE, 8'h00);
      // Distinct pattern into every bank, floppy_drive_ident written everywhere
      for (int d = 0; d < NDEV; d++) begin
         cfg_wr(IX_LDN, d[7:0]);
         for (int k = 0; k < 11; k++) cfg_wr(DEV_IX[k], pat(d, k));
         cfg_wr(IX_FLOPPY_DRIVE_IDENT, ~d[7:0]);
      end
      cfg_wr(IX_LDN, NDEV_B);
      cfg_wr(IX_ACT, 8'hFF);
      cfg_chk("sel09 act", IX_ACT, 8'h00);
      // Read back: no bank disturbed by writes to the others
      for (int d = 0; d < NDEV; d++) begin
         cfg_wr(IX_LDN, d[7:0]);
         cfg_chk("chip id", IX_CHIPID, TEST_ID);
         for (int k = 0; k < 11; k++)
            cfg_chk("bank reg", DEV_IX[k], pat(d, k));
         cfg_chk("floppy_drive_ident", IX_FLOPPY_DRIVE_IDENT,
                 (d == 3) ? ~d[7:0] : 8'h00);
      end
      host.io_rd(IDX_PORT, rd_data, rd_ok);
      chk("index held", {8'h00, IX_FLOPPY_DRIVE_IDENT}, {8'h00, rd_data});
      cfg_wr(IX_GCFG_A, 8'h3C);
      cfg_chk("gcfg_a wr", IX_GCFG_A, 8'h3C);
      cfg_wr(IX_CS_IDX, 8'h05);
      cfg_wr(IX_CS_DAT, 8'h77);
      cfg_wr(IX_CS_IDX, 8'h02);
      cfg_chk("cs entry 2", IX_CS_DAT, 8'h00);
      cfg_wr(IX_CS_IDX, 8'h05);
      cfg_chk("cs entry 5", IX_CS_DAT, 8'h77);
      // Run-time decode, gated by each device's activation bit
      foreach (RT_ADDR[j]) begin
         cfg_wr(IX_LDN, (j == 0) ? 8'h00 : 8'h02 + j[7:0]);
         cfg_wr(IX_ACT, 8'h01);
      end
      foreach (RT_ADDR[j]) begin
         host.io_strobe(RT_ADDR[j]);
         chk("rt_sel", {11'h0, RT_EXP[j]}, {11'h0, rt_sel});
      end
      cfg_wr(IX_LDN, 8'h00);
      cfg_wr(IX_ACT, 8'h00);
      host.io_strobe(16'h0064);
      chk("rt_sel off", 16'h0, {11'h0, rt_sel});
      host.io_rd(16'h0200, rd_data, rd_ok);
      chk("unmapped ack", 16'h0, {15'h0, rd_ok});
      // GPIO ports: direction, latch, pin read-back
      host.io_wr(GPIO_BASE + 16'h1, 8'hFF);
      chk("oe port1", 16'h00F, {5'h0, gpio_oe});
      host.io_wr(GPIO_BASE, 8'h05);
      host.io_wr(GPIO_BASE + 16'h5, 8'hFE);
      host.io_wr(GPIO_BASE + 16'h4, 8'hAA);
      chk("oe both", 16'h7FF, {5'h0, gpio_oe});
      chk("out both", 16'h555, {5'h0, gpio_out});
      host.io_rd(GPIO_BASE + 16'h4, rd_data, rd_ok);
      chk("port2 latch", 16'h00AA, {8'h00, rd_data});
      gpio_in = 11'h5A3;
      host.io_wr(GPIO_BASE + 16'h1, 8'h00);
      host.io_wr(GPIO_BASE + 16'h5, 8'h00);
      host.io_rd(GPIO_BASE, rd_data, rd_ok);
      chk("port1 pins", 16'h0003, {8'h00, rd_data});
      host.io_rd(GPIO_BASE + 16'h4, rd_data, rd_ok);
      chk("port2 pins", 16'h00B4, {8'h00, rd_data});
      // Strap low: config ports not decoded at all
      do_reset(1'b0);
      chk("cfg_en low", 16'h0, {15'h0, cfg_en});
      host.io_rd(DAT_PORT, rd_data, rd_ok);
      chk("no strap ack", 16'h0, {15'h0, rd_ok});
      do_reset(1'b1);
      cfg_chk("gcfg_a again", IX_GCFG_A, 8'hD6);
      stop_test();
   end
endmodule // superio_indexed_config_port_bench
